// ---- design/tss_scheduler.sv ----
// Purpose: TDMA slot scheduler with APB register file
// Assumes: pclk 25 MHz, link-side inputs synchronous to pclk
// Notes:   Timing settings take effect on an apply (reboot) write
// What this block does
// - Holds a 64-bit ownership mask, bit i for slot i, from zero.
// - Slot duration is the whole slot length in microseconds, idle included.
// - A cycle is slot-count slots, about count times duration long.
// - Permission bit 0 allows transmit in owned slots; expected set.
// - Permission bit 1 allows transmit in slots given up by others.
// - Permission bit 2 allows sync-slot transmit only when master.
// - Permission field resets to 7, all permissions on.
// - At apply, duration is adjusted if payload falls outside 300..1000 bytes, unless rate is zero.
// - Antenna mode: 0 diversity, 1 first, 2 second, 3 tx first rx second.
// - Diversity transmits on the port with strongest last receive.
// - Channel spacing is frequency span over channel count plus one.
// - A single channel sits midway between the frequency limits.
// - Extended range lengthens the quiet gap, costing throughput.
// - Linking mode 0 takes master from the control master bit, 1 is automatic.
// - Automatic linking works only for exactly two nodes.
`timescale 1ns/10ps
`include "tss_consts.svh"
module tss_scheduler
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        slot_released,
    input  wire logic        sync_slot,
    input  wire logic        auto_master,
    input  wire logic        rssi_valid,
    input  wire logic [7:0]  rssi_first,
    input  wire logic [7:0]  rssi_second,
    output logic             tx_enable,
    output logic             tx_antenna_sel,
    output logic             rx_antenna_sel,
    output logic [5:0]       slot_index,
    output logic             cycle_start
);
    tss_pkg::tss_state_t r;
    tss_pkg::tss_state_t n;
    logic                div_done;
    logic [31:0]         div_q;
    logic [39:0]         prod;
    logic [31:0]         span;
    logic                master;
    logic                cfg_err;
    logic                slot_end;
    logic                in_guard;
    logic                allow;
    logic [31:0]         status;

    tss_divider u_div
    (
        .pclk     (pclk),
        .presetn  (presetn),
        .start    (r.div_start),
        .dividend (r.div_dnd),
        .divisor  (r.div_dsr),
        .done     (div_done),
        .quotient (div_q)
    );

    always_comb
    begin
        n           = r;
        n.div_start = 1'b0;
        n.cycle_start = 1'b0;
        n.pready    = 1'b0;
        n.pslverr   = 1'b0;
        prod        = {16'h0, r.eff_us} * {24'h0, r.rate};
        span        = r.fmax - r.fmin;
        master      = r.link_mode ? auto_master : r.master_cfg;
        cfg_err     = r.link_mode && (r.act_cnt != 7'h02);
        slot_end    = (r.us_div == 5'(`TSS_US_CYC - 1)) && (r.us_cnt == r.eff_us - 24'h1);
        in_guard    = r.xr_en && (r.eff_us > `TSS_XR_GUARD_US)
                      && (r.us_cnt >= r.eff_us - `TSS_XR_GUARD_US);
        allow       = (r.perm[0] && r.mask[r.idx])
                      || (r.perm[1] && slot_released)
                      || (r.perm[2] && master && sync_slot);
        status      = 32'h0;
        status[`TSS_ST_IDX_LSB +: 6] = r.idx;
        status[`TSS_ST_TXEN_BIT]     = r.tx_en;
        status[`TSS_ST_TXANT_BIT]    = r.tx_ant;
        status[`TSS_ST_RXANT_BIT]    = r.rx_ant;
        status[`TSS_ST_RUN_BIT]      = r.run;
        status[`TSS_ST_ERR_BIT]      = cfg_err;
        status[`TSS_ST_MST_BIT]      = master;

        // APB setup phase: answer in the following access cycle
        if (psel && !penable)
        begin
            n.pready = 1'b1;
            n.prdata = 32'h0;
            unique case (paddr)
                `TSS_OFF_CTRL:
                    n.prdata = {24'h0, r.master_cfg, r.link_mode, r.xr_en,
                                r.ant_mode, r.perm};
                `TSS_OFF_APPLY:    n.prdata = 32'h0;
                `TSS_OFF_SLOT_US:  n.prdata = {8'h0, r.slot_us};
                `TSS_OFF_SLOT_CNT: n.prdata = {25'h0, r.slot_cnt};
                `TSS_OFF_MASK_LO:  n.prdata = r.mask[31:0];
                `TSS_OFF_MASK_HI:  n.prdata = r.mask[63:32];
                `TSS_OFF_FMIN:     n.prdata = r.fmin;
                `TSS_OFF_FMAX:     n.prdata = r.fmax;
                `TSS_OFF_NCH:      n.prdata = {24'h0, r.nch};
                `TSS_OFF_RATE:     n.prdata = {16'h0, r.rate};
                `TSS_OFF_STATUS:   n.prdata = status;
                `TSS_OFF_EFF_US:   n.prdata = {8'h0, r.eff_us};
                `TSS_OFF_SPACING:  n.prdata = r.spacing;
                `TSS_OFF_FIRST_CH: n.prdata = r.first_ch;
                default:           n.pslverr = 1'b1;
            endcase
        end

        // Write takes effect at the access edge
        if (psel && penable && r.pready && pwrite && !r.pslverr)
        begin
            unique case (paddr)
                `TSS_OFF_CTRL:
                begin
                    n.perm       = pwdata[`TSS_CTRL_PERM_LSB +: 3];
                    n.ant_mode   = pwdata[`TSS_CTRL_ANT_LSB +: 2];
                    n.xr_en      = pwdata[`TSS_CTRL_XR_BIT];
                    n.link_mode  = pwdata[`TSS_CTRL_LINK_BIT];
                    n.master_cfg = pwdata[`TSS_CTRL_MST_BIT];
                end
                `TSS_OFF_APPLY:
                begin
                    if (pwdata[`TSS_APPLY_BIT])
                    begin
                        // Latch cycle geometry: slot count clamped to 1..64, slot duration to at least 1
                        n.eff_us  = (r.slot_us == 24'h0) ? 24'h1 : r.slot_us;
                        n.act_cnt = (r.slot_cnt == 7'h0) ? 7'h1
                                  : (r.slot_cnt > `TSS_MAX_SLOTS) ? `TSS_MAX_SLOTS
                                  : r.slot_cnt;
                        n.run     = 1'b0;
                        n.tx_en   = 1'b0;
                        n.phase   = tss_pkg::ST_CHECK;
                    end
                end
                `TSS_OFF_SLOT_US:  n.slot_us  = pwdata[23:0];
                `TSS_OFF_SLOT_CNT: n.slot_cnt = pwdata[6:0];
                `TSS_OFF_MASK_LO:  n.mask[31:0]  = pwdata;
                `TSS_OFF_MASK_HI:  n.mask[63:32] = pwdata;
                `TSS_OFF_FMIN:     n.fmin = pwdata;
                `TSS_OFF_FMAX:     n.fmax = pwdata;
                `TSS_OFF_NCH:      n.nch  = pwdata[7:0];
                `TSS_OFF_RATE:     n.rate = pwdata[15:0];
                default:           n.pslverr = 1'b0;
            endcase
        end

        if (rssi_valid)
            n.best_ant = (rssi_second > rssi_first);

        unique case (r.ant_mode)
            2'h0:
            begin
                n.tx_ant = r.best_ant;
                n.rx_ant = r.best_ant;
            end
            2'h1:
            begin
                n.tx_ant = 1'b0;
                n.rx_ant = 1'b0;
            end
            2'h2:
            begin
                n.tx_ant = 1'b1;
                n.rx_ant = 1'b1;
            end
            2'h3:
            begin
                n.tx_ant = 1'b0;
                n.rx_ant = 1'b1;
            end
        endcase

        unique case (r.phase)
            tss_pkg::ST_IDLE:
            begin
                n.run = 1'b0;
            end
            tss_pkg::ST_CHECK:
            begin
                if (r.rate != 16'h0 && prod < `TSS_LOW_PROD)
                begin
                    n.div_dnd   = `TSS_LOW_PROD32 + {16'h0, r.rate} - 32'h1;
                    n.div_dsr   = {16'h0, r.rate};
                    n.div_start = 1'b1;
                    n.phase     = tss_pkg::ST_ADJW;
                end
                else if (r.rate != 16'h0 && prod > `TSS_HIGH_PROD)
                begin
                    n.div_dnd   = `TSS_HIGH_PROD32;
                    n.div_dsr   = {16'h0, r.rate};
                    n.div_start = 1'b1;
                    n.phase     = tss_pkg::ST_ADJW;
                end
                else
                begin
                    n.div_dnd   = span;
                    n.div_dsr   = {24'h0, r.nch} + 32'h1;
                    n.div_start = 1'b1;
                    n.phase     = tss_pkg::ST_SPCW;
                end
            end
            tss_pkg::ST_ADJW:
            begin
                if (div_done)
                begin
                    n.eff_us    = div_q[23:0];
                    n.div_dnd   = span;
                    n.div_dsr   = {24'h0, r.nch} + 32'h1;
                    n.div_start = 1'b1;
                    n.phase     = tss_pkg::ST_SPCW;
                end
            end
            tss_pkg::ST_SPCW:
            begin
                if (div_done)
                begin
                    n.spacing = div_q;
                    n.first_ch = (r.nch == 8'h1) ? r.fmin + {1'b0, span[31:1]}
                                                 : r.fmin + div_q;
                    n.us_div  = 5'h0;
                    n.us_cnt  = 24'h0;
                    n.idx     = 6'h0;
                    n.run     = 1'b1;
                    n.cycle_start = 1'b1;
                    n.phase   = tss_pkg::ST_RUN;
                end
            end
            tss_pkg::ST_RUN:
            begin
                if (r.us_div == 5'(`TSS_US_CYC - 1))
                begin
                    n.us_div = 5'h0;
                    n.us_cnt = r.us_cnt + 24'h1;
                end
                else
                begin
                    n.us_div = r.us_div + 5'h1;
                end
                if (slot_end)
                begin
                    n.us_cnt = 24'h0;
                    if ({1'b0, r.idx} == r.act_cnt - 7'h1)
                    begin
                        n.idx = 6'h0;
                        n.cycle_start = 1'b1;
                    end
                    else
                    begin
                        n.idx = r.idx + 6'h1;
                    end
                end
                n.tx_en = allow && !in_guard && !cfg_err && !slot_end;
            end
            default:
            begin
                n.phase = tss_pkg::ST_IDLE;
                n.run   = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r          <= '0;
            r.perm     <= `TSS_PERM_RST;
            r.slot_us  <= `TSS_SLOT_US_RST;
            r.slot_cnt <= `TSS_SLOT_CNT_RST;
            r.eff_us   <= `TSS_SLOT_US_RST;
            r.act_cnt  <= `TSS_SLOT_CNT_RST;
            r.nch      <= `TSS_NCH_RST;
            r.rate     <= `TSS_RATE_RST;
            r.phase    <= tss_pkg::ST_IDLE;
        end
        else
        begin
            r <= n;
        end
    end

    assign pready         = r.pready;
    assign prdata         = r.prdata;
    assign pslverr        = r.pslverr;
    assign tx_enable      = r.tx_en;
    assign tx_antenna_sel = r.tx_ant;
    assign rx_antenna_sel = r.rx_ant;
    assign slot_index     = r.idx;
    assign cycle_start    = r.cycle_start;
endmodule

// ---- design/tss_consts.svh ----
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 32-bit APB data, one word per register
// Notes:   Included by package users and the scheduler top
`ifndef TSS_CONSTS_SVH
`define TSS_CONSTS_SVH

`define TSS_OFF_CTRL        8'h00
`define TSS_OFF_APPLY       8'h04
`define TSS_OFF_SLOT_US     8'h08
`define TSS_OFF_SLOT_CNT    8'h0c
`define TSS_OFF_MASK_LO     8'h10
`define TSS_OFF_MASK_HI     8'h14
`define TSS_OFF_FMIN        8'h18
`define TSS_OFF_FMAX        8'h1c
`define TSS_OFF_NCH         8'h20
`define TSS_OFF_RATE        8'h24
`define TSS_OFF_STATUS      8'h28
`define TSS_OFF_EFF_US      8'h2c
`define TSS_OFF_SPACING     8'h30
`define TSS_OFF_FIRST_CH    8'h34

`define TSS_CTRL_PERM_LSB   0
`define TSS_CTRL_ANT_LSB    3
`define TSS_CTRL_XR_BIT     5
`define TSS_CTRL_LINK_BIT   6
`define TSS_CTRL_MST_BIT    7
`define TSS_APPLY_BIT       0

`define TSS_ST_IDX_LSB      0
`define TSS_ST_TXEN_BIT     8
`define TSS_ST_TXANT_BIT    9
`define TSS_ST_RXANT_BIT    10
`define TSS_ST_RUN_BIT      11
`define TSS_ST_ERR_BIT      12
`define TSS_ST_MST_BIT      13

`define TSS_PERM_RST        3'h7
`define TSS_SLOT_US_RST     24'h000fa0
`define TSS_SLOT_CNT_RST    7'h02
`define TSS_NCH_RST         8'h01
`define TSS_RATE_RST        16'h0040
`define TSS_MAX_SLOTS       7'h40

`define TSS_PAYLOAD_MIN_B   300
`define TSS_PAYLOAD_MAX_B   1000
`define TSS_BITS_PER_KBPS_US 8000
`define TSS_LOW_PROD        40'd2400000
`define TSS_HIGH_PROD       40'd8000000
`define TSS_LOW_PROD32      32'd2400000
`define TSS_HIGH_PROD32     32'd8000000

`define TSS_CLK_PERIOD_NS   40
`define TSS_US_NS           1000
`define TSS_US_CYC          (`TSS_US_NS / `TSS_CLK_PERIOD_NS)
`define TSS_XR_GUARD_US     24'h000064

`endif

// ---- design/tss_pkg.sv ----
// Purpose: Types shared by the slot scheduler and its divider
// Assumes: Constants come from tss_consts.svh
// Notes:   One-hot state codes
package tss_pkg;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_CHECK = 5'b00010,
        ST_ADJW  = 5'b00100,
        ST_SPCW  = 5'b01000,
        ST_RUN   = 5'b10000
    } tss_phase_t;

    typedef struct packed {
        logic        busy;
        logic        done;
        logic [5:0]  step;
        logic [31:0] rem;
        logic [31:0] quo;
        logic [31:0] dsr;
    } tss_div_t;

    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
        logic [2:0]  perm;
        logic [1:0]  ant_mode;
        logic        xr_en;
        logic        link_mode;
        logic        master_cfg;
        logic [23:0] slot_us;
        logic [6:0]  slot_cnt;
        logic [63:0] mask;
        logic [31:0] fmin;
        logic [31:0] fmax;
        logic [7:0]  nch;
        logic [15:0] rate;
        logic [23:0] eff_us;
        logic [6:0]  act_cnt;
        logic [31:0] spacing;
        logic [31:0] first_ch;
        tss_phase_t  phase;
        logic        run;
        logic [4:0]  us_div;
        logic [23:0] us_cnt;
        logic [5:0]  idx;
        logic        best_ant;
        logic        tx_en;
        logic        tx_ant;
        logic        rx_ant;
        logic        cycle_start;
        logic        div_start;
        logic [31:0] div_dnd;
        logic [31:0] div_dsr;
    } tss_state_t;

endpackage

// ---- design/tss_divider.sv ----
// Purpose: Unsigned 32-bit restoring divider, one quotient bit per cycle
// Assumes: start is a one-cycle pulse while not busy
// Notes:   Division by zero returns all ones
`timescale 1ns/10ps
`include "tss_consts.svh"
module tss_divider
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        start,
    input  wire logic [31:0] dividend,
    input  wire logic [31:0] divisor,
    output logic             done,
    output logic [31:0]      quotient
);
    tss_pkg::tss_div_t r;
    tss_pkg::tss_div_t n;
    logic [32:0]       trial;

    always_comb
    begin
        n     = r;
        n.done = 1'b0;
        trial = {r.rem, r.quo[31]} - {1'b0, r.dsr};
        if (start && !r.busy)
        begin
            n.busy = 1'b1;
            n.step = 6'h00;
            n.rem  = 32'h0;
            n.quo  = dividend;
            n.dsr  = divisor;
        end
        else if (r.busy)
        begin
            if (r.dsr == 32'h0)
            begin
                n.quo  = 32'hffffffff;
                n.busy = 1'b0;
                n.done = 1'b1;
            end
            else
            begin
                if (!trial[32])
                begin
                    n.rem = trial[31:0];
                    n.quo = {r.quo[30:0], 1'b1};
                end
                else
                begin
                    n.rem = {r.rem[30:0], r.quo[31]};
                    n.quo = {r.quo[30:0], 1'b0};
                end
                n.step = r.step + 6'h01;
                if (r.step == 6'h1f)
                begin
                    n.busy = 1'b0;
                    n.done = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            r <= '0;
        else
            r <= n;
    end

    assign done     = r.done;
    assign quotient = r.quo;
endmodule

// ---- tb/tss_peer_model.sv ----
// Purpose: Peer modem stand-in on the shared slotted air link
// Assumes: Peer owns slot 1 only and gives it up; slot 3 is the sync slot
// Notes:   Strength lines carry junk between pulses
`timescale 1ns/10ps
module tss_peer_model
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [5:0] slot_index,
    input  wire logic       strong_second,
    input  wire logic       peer_master,
    output logic            slot_released,
    output logic            sync_slot,
    output logic            auto_master,
    output logic            rssi_valid,
    output logic [7:0]      rssi_first,
    output logic [7:0]      rssi_second
);
    logic [2:0] tick;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tick          <= 3'h0;
            slot_released <= 1'b0;
            sync_slot     <= 1'b0;
            auto_master   <= 1'b0;
            rssi_valid    <= 1'b0;
            rssi_first    <= 8'h00;
            rssi_second   <= 8'hff;
        end
        else
        begin
            tick          <= tick + 3'h1;
            slot_released <= (slot_index == 6'h01);
            sync_slot     <= (slot_index == 6'h03);
            auto_master   <= peer_master;
            rssi_valid    <= (tick == 3'h7);
            rssi_first    <= (tick == 3'h7) ? 8'h40 : ~rssi_first;
            rssi_second   <= (tick == 3'h7) ? (strong_second ? 8'h80 : 8'h20) : ~rssi_second;
        end
    end
endmodule

// ---- tb/tss_scheduler_assertions.sv ----
// Purpose: Port-level checks of the slot scheduler
// Assumes: Shadows of control and mask built from APB writes
// Notes:   Bound into every scheduler instance
`timescale 1ns/10ps
`include "tss_consts.svh"
module tss_scheduler_assertions
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        slot_released,
    input wire logic        sync_slot,
    input wire logic        rssi_valid,
    input wire logic [7:0]  rssi_first,
    input wire logic [7:0]  rssi_second,
    input wire logic        tx_enable,
    input wire logic        tx_antenna_sel,
    input wire logic        rx_antenna_sel,
    input wire logic [5:0]  slot_index,
    input wire logic        cycle_start
);
    logic [7:0]  sh_ctrl;
    logic [7:0]  sh_app;
    logic [63:0] sh_mask;
    wire  [2:0]  sh_perm = sh_ctrl[2:0];
    wire         wr      = psel && penable && pready && pwrite;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sh_ctrl <= 8'h07;
            sh_app  <= 8'h07;
            sh_mask <= 64'h0;
        end
        else if (wr)
        begin
            if (paddr == `TSS_OFF_CTRL)
                sh_ctrl <= pwdata[7:0];
            if (paddr == `TSS_OFF_APPLY && pwdata[0])
                sh_app <= sh_ctrl;
            if (paddr == `TSS_OFF_MASK_LO)
                sh_mask[31:0] <= pwdata;
            if (paddr == `TSS_OFF_MASK_HI)
                sh_mask[63:32] <= pwdata;
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_ready;
        psel && !penable |=> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("no ready after setup");
    property p_ready_acc;
        pready |-> psel && penable;
    endproperty
    a_ready_acc: assert property (p_ready_acc) else $error("ready outside access");
    property p_unmapped;
        psel && !penable && paddr > `TSS_OFF_FIRST_CH |=> pready && pslverr;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
    property p_err_ready;
        pslverr |-> pready;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
    property p_idx;
        slot_index != $past(slot_index) |->
            slot_index == 6'h00 || slot_index == $past(slot_index) + 6'h01;
    endproperty
    a_idx: assert property (p_idx) else $error("slot index skipped");
    property p_pulse;
        cycle_start |=> !cycle_start;
    endproperty
    a_pulse: assert property (p_pulse) else $error("cycle start too long");
    property p_tx;
        tx_enable |-> $past((sh_perm[0] && sh_mask[slot_index]) ||
            (sh_perm[1] && slot_released) || (sh_perm[2] && sync_slot));
    endproperty
    a_tx: assert property (p_tx) else $error("transmit not permitted");
    property p_ant;
        sh_app[4:3] != 2'h0 && sh_app[4:3] == sh_ctrl[4:3] && sh_app == $past(sh_app, 2)
            |-> tx_antenna_sel == (sh_app[4:3] == 2'h2) && rx_antenna_sel == sh_app[4];
    endproperty
    a_ant: assert property (p_ant) else $error("antenna port wrong");
    property p_div;
        sh_app[4:3] == 2'h0 && sh_ctrl[4:3] == 2'h0 && rssi_valid
            && rssi_second > rssi_first |-> ##[1:3] tx_antenna_sel;
    endproperty
    a_div: assert property (p_div) else $error("diversity port wrong");
    c_start: cover property (cycle_start);
    c_tx: cover property (tx_enable);
    c_err: cover property (pslverr);
    c_ant: cover property (tx_antenna_sel);
endmodule
bind tss_scheduler tss_scheduler_assertions chk (.*);

// ---- tb/tss_scheduler_bench.sv ----
// Purpose: Self-checking bench of the slot scheduler
// Assumes: APB master here, peer model on the link side
// Notes:   Reads are noted in a queue and compared by a monitor
`timescale 1ns/10ps
`include "tss_consts.svh"
module tss_scheduler_bench;
    typedef struct packed {
        logic        e;
        logic [31:0] m;
        logic [31:0] d;
    } tss_exp_t;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        slot_released, sync_slot, auto_master, rssi_valid, tx_enable;
    logic        tx_antenna_sel, rx_antenna_sel, cycle_start, strong_second, peer_master;
    logic [7:0]  paddr, rssi_first, rssi_second;
    logic [31:0] pwdata, prdata, seed;
    logic [5:0]  slot_index;
    int          err_total, n_checks, cyc;
    tss_exp_t    exp_q[$];
    tss_exp_t    e;
    tss_scheduler uut (.*);
    tss_peer_model peer (.*);
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic test_done;
        if (exp_q.size() != 0)
            err_total++;
        if (err_total == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                      input logic er = 1'b0);
        exp_q.push_back({er, m, d});
        apb(a, 1'b0, 32'h0);
    endtask
    task automatic wait_start;
        do
            @(posedge pclk);
        while (cycle_start !== 1'b1);
    endtask
    always @(posedge pclk)
    begin
        if (psel && penable && pready === 1'b1 && !pwrite)
        begin
            e = exp_q.pop_front();
            chk({pslverr, prdata & e.m}, {e.e, e.d & e.m});
        end
    end
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            err_total++;
            test_done();
        end
    end
    logic [31:0] tab [2][6] = '{'{10, 8000, 4, 300, 500, 900500},
                               '{2000, 8000, 1, 1000, 1250, 901250}};
    logic [7:0]  ctab [5] = '{8'h89, 8'h92, 8'h9c, 8'h04, 8'h83};
    initial
    begin
        int          i, k;
        logic [7:0]  c;
        logic [31:0] ex, mk, cnt;
        logic        t, ta;
        presetn       = 1'b0;
        psel          = 1'b0;
        penable       = 1'b0;
        pwrite        = 1'b0;
        paddr         = 8'h00;
        pwdata        = 32'h0;
        strong_second = 1'b0;
        peer_master   = 1'b0;
        seed          = 32'h1617;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`TSS_OFF_CTRL, 32'h7, '1);
        rd(`TSS_OFF_STATUS, 32'h0, 32'h800);
        rd(8'h3c, 32'h0, '1, 1'b1);
        for (i = 0; i < 2; i++)
        begin
            seed = lfsr_next(seed);
            wr(`TSS_OFF_MASK_LO + 8'(4 * i), seed);
            rd(`TSS_OFF_MASK_LO + 8'(4 * i), seed, '1);
        end
        wr(`TSS_OFF_FMIN, 32'd900000);
        wr(`TSS_OFF_FMAX, 32'd902500);
        for (i = 0; i < 2; i++)
        begin
            wr(`TSS_OFF_SLOT_US, tab[i][0]);
            wr(`TSS_OFF_RATE, tab[i][1]);
            wr(`TSS_OFF_NCH, tab[i][2]);
            wr(`TSS_OFF_APPLY, 32'h1);
            wait_start();
            rd(`TSS_OFF_EFF_US, tab[i][3], '1);
            rd(`TSS_OFF_SPACING, tab[i][4], '1);
            rd(`TSS_OFF_FIRST_CH, tab[i][5], '1);
        end
        wr(`TSS_OFF_RATE, 32'h0);
        wr(`TSS_OFF_SLOT_US, 32'd4);
        wr(`TSS_OFF_SLOT_CNT, 32'd4);
        wr(`TSS_OFF_MASK_LO, 32'h5);
        wr(`TSS_OFF_MASK_HI, 32'h0);
        for (i = 0; i < 5; i++)
        begin
            c = ctab[i];
            strong_second <= (i == 3);
            wr(`TSS_OFF_CTRL, {24'h0, c});
            wr(`TSS_OFF_APPLY, 32'h1);
            wait_start();
            repeat (50) @(posedge pclk);
            for (k = 0; k < 5; k++)
            begin
                t  = (c[0] && !k[0]) || (c[1] && k[1:0] == 2'h1) || (c[2] && c[7] && k[1:0] == 2'h3);
                ta = (c[4:3] == 2'h0) ? (i == 3) : (c[4:3] == 2'h2);
                ex = {18'h0, c[7], 2'h1, c[4], ta, t, 6'h0, k[1:0]};
                mk = (c[4:3] == 2'h0) ? 32'h3b3f : 32'h3f3f;
                rd(`TSS_OFF_STATUS, ex, mk);
                repeat (97) @(posedge pclk);
            end
        end
        wait_start();
        cnt = 32'h0;
        do
        begin
            @(posedge pclk);
            cnt++;
        end
        while (cycle_start !== 1'b1);
        chk({1'b0, cnt}, 33'd400);
        wr(`TSS_OFF_CTRL, 32'h41);
        wr(`TSS_OFF_APPLY, 32'h1);
        repeat (150) @(posedge pclk);
        rd(`TSS_OFF_STATUS, 32'h1000, 32'h1100);
        peer_master <= 1'b1;
        wr(`TSS_OFF_SLOT_CNT, 32'd2);
        wr(`TSS_OFF_APPLY, 32'h1);
        wait_start();
        rd(`TSS_OFF_STATUS, 32'h2000, 32'h3000);
        wr(`TSS_OFF_CTRL, 32'h21);
        wr(`TSS_OFF_MASK_LO, '1);
        wr(`TSS_OFF_SLOT_US, 32'd200);
        wr(`TSS_OFF_APPLY, 32'h1);
        wait_start();
        repeat (1250) @(posedge pclk);
        rd(`TSS_OFF_STATUS, 32'h100, 32'h100);
        repeat (2500) @(posedge pclk);
        rd(`TSS_OFF_STATUS, 32'h0, 32'h100);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`TSS_OFF_STATUS, 32'h0, 32'h800);
        rd(`TSS_OFF_CTRL, 32'h7, '1);
        test_done();
    end
endmodule
